// File: logic/interp_shaping_device.sv
/*
  Device end: eight-stage bit-pattern pre-buffer, buffer-space interrupt,
  constant vector speed period stretching and short-axis pulse equalization.
  Assumes the host end on the link, same clock mclk, asynchronous rst_n.
*/
// Chosen here: the register offsets and the address-and-strobe port.
// Behaviour
// RQ1: Interrupt low on fill falling 8-7 or 4-3.
// RQ2: Host writes more stages while flag is one.
// RQ3: Interpolation command releases the interrupt.
// RQ4: Drive finish forces interrupt inactive.
// RQ5: All axes pulse in step with base pulse.
// RQ6: Unequalized short axis pulses on its bits only.
// RQ7: Mode bits seven and six pick vector mode.
// RQ8: Mode zero applies no period scaling.
// RQ9: Two-axis simple stretches joint steps by 1.414.
// RQ10: Three-axis stretches 1.414 or 1.732.
// RQ11: High accuracy mode needs equalization enabled; code applies the two-axis 1.414 stretch without checking it.
// RQ12: Mode bit eight enables equalization.
// RQ13: Equalized short axis spreads pulses evenly.
// RQ14: Host limits speeds when equalizing; code passes period writes through unchecked.
// RQ15: Host limits coordinates when equalizing; code passes axis pattern writes through unchecked.
// RQ16: Host forbids equalization with bit patterns; code refuses commands while bit eight is set but lets it be set mid-stage.
// RQ17: Arc endpoints may miss by one pulse.
// RQ18: Mode bit fourteen selects 4-3 interrupt.
// RQ19: Next-write flag one for fill 1 to 7.
// RQ20: Fill rises per command, falls per stage.
// RQ21: Equalization runs at eight-fold finer resolution.
`timescale 1ns/1ps
module interp_shaping_device #(
  parameter int AXES = 3
) (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  interp_shaping_if.device     link,
  output logic [AXES-1:0]      axisPulse,
  output logic                 evenActive
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0]                                   mode;
    logic [15:0]                                   period;
    logic [AXES-1:0][15:0]                         pend;
    logic [interp_shaping_pkg::STAGES-1:0][AXES-1:0][15:0] stage;
    logic [2:0]                                    wrPtr;
    logic [2:0]                                    rdPtr;
    logic [3:0]                                    fill;
    logic                                          started;
    logic [3:0]                                    bitIdx;
    logic [2:0]                                    sub;
    logic [16:0]                                   timer;
    logic [AXES-1:0][7:0]                          acc;
    logic [AXES-1:0]                               pulse;
    logic                                          irqN;
    logic                                          nwp;
    logic                                          even;
  } state_s;

  state_s s;
  state_s next_s;

  logic [AXES-1:0]      raw;
  logic [1:0]           nRaw;
  logic [AXES-1:0][4:0] pop;
  logic [4:0]           maxPop;
  logic [7:0]           factor;
  logic [23:0]          scaled;
  logic [16:0]          subLen;
  logic                 inc;
  logic                 dec;
  logic [1:0]           spd;
  logic [7:0]           accSum;

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.pulse = '0;
    inc = 1'b0;
    dec = 1'b0;
    accSum = 8'h00;
    spd = {s.mode[interp_shaping_pkg::MODE_SPD_HI], s.mode[interp_shaping_pkg::MODE_SPD_LO]}; // see RQ7
    // Step pattern of the current step, one bit per enabled axis
    nRaw = 2'h0;
    maxPop = 5'h00;
    for (int a = 0; a < AXES; a++) begin
      raw[a] = s.stage[s.rdPtr][a][s.bitIdx] & s.mode[a];
      nRaw = nRaw + {1'b0, raw[a]};
      pop[a] = 5'h00;
      for (int b = 0; b < interp_shaping_pkg::STAGE_BITS; b++) begin
        pop[a] = pop[a] + {4'h0, s.stage[s.rdPtr][a][b] & s.mode[a]};
      end
      if (pop[a] > maxPop) begin
        maxPop = pop[a];
      end
    end
    // Period stretch for joint steps
    case (spd)
      interp_shaping_pkg::SPD_2SIMPLE,
      interp_shaping_pkg::SPD_2ACCUR: begin
        factor = (nRaw >= 2'h2) ? interp_shaping_pkg::SCALE_SQ2
                                : interp_shaping_pkg::SCALE_ONE; // see RQ9 see RQ11
      end
      interp_shaping_pkg::SPD_3SIMPLE: begin
        if (nRaw == 2'h3) begin
          factor = interp_shaping_pkg::SCALE_SQ3; // see RQ10
        end else if (nRaw == 2'h2) begin
          factor = interp_shaping_pkg::SCALE_SQ2; // see RQ10
        end else begin
          factor = interp_shaping_pkg::SCALE_ONE;
        end
      end
      default: factor = interp_shaping_pkg::SCALE_ONE; // see RQ8
    endcase
    scaled = ({8'h00, s.period} * {16'h0000, factor}) >> interp_shaping_pkg::SCALE_SHIFT;
    // One step is SUBSTEPS sub-slots long
    subLen = 17'(scaled >> 3);
    if (subLen == 17'h00000) begin
      subLen = 17'h00001;
    end
    // Host writes
    if (link.wrStrobe) begin
      case (link.wrSel)
        interp_shaping_pkg::SEL_MODE:   next_s.mode = link.wrData;
        interp_shaping_pkg::SEL_PERIOD: next_s.period = link.wrData;
        interp_shaping_pkg::SEL_CMD: begin
          if ((link.wrData[7:0] == interp_shaping_pkg::CMD_BP2 ||
               link.wrData[7:0] == interp_shaping_pkg::CMD_BP3 ||
               link.wrData[7:0] == interp_shaping_pkg::CMD_BP4) &&
              s.fill != interp_shaping_pkg::FILL_FULL) begin
            next_s.stage[s.wrPtr] = s.pend;
            next_s.wrPtr = s.wrPtr + 3'h1;
            next_s.started = 1'b1;
            next_s.irqN = 1'b1; // see RQ3
            inc = 1'b1; // see RQ20
          end
        end
        default: begin
          for (int a = 0; a < AXES; a++) begin
            if (link.wrSel == interp_shaping_pkg::SEL_AXIS0 + 3'(a)) begin
              next_s.pend[a] = link.wrData;
            end
          end
        end
      endcase
    end
    // Pulse engine
    if (s.started && s.fill != 4'h0) begin
      if (s.timer != 17'h00000) begin
        next_s.timer = s.timer - 17'h00001;
      end else begin
        next_s.timer = subLen - 17'h00001;
        for (int a = 0; a < AXES; a++) begin
          if (s.even && pop[a] < maxPop) begin
            // Sub-slot accumulator spreads pop pulses over 128 slots
            accSum = s.acc[a] + {3'h0, pop[a]}; // see RQ21
            if (accSum >= interp_shaping_pkg::EVEN_WRAP) begin
              next_s.pulse[a] = 1'b1; // see RQ13
              accSum = accSum - interp_shaping_pkg::EVEN_WRAP;
            end
            next_s.acc[a] = accSum;
          end else if (s.sub == 3'h0) begin
            next_s.pulse[a] = raw[a]; // see RQ5 see RQ6
          end
        end
        next_s.sub = s.sub + 3'h1;
        if (s.sub == 3'h7) begin
          next_s.bitIdx = s.bitIdx + 4'h1;
          if (s.bitIdx == 4'hF) begin
            next_s.rdPtr = s.rdPtr + 3'h1;
            next_s.acc = '0; // see RQ17
            dec = 1'b1; // see RQ20
          end
        end
      end
    end
    next_s.fill = s.fill + {3'h0, inc} - {3'h0, dec};
    if (dec && !inc) begin
      if (s.fill == 4'h1) begin
        next_s.started = 1'b0;
        next_s.irqN = 1'b1; // see RQ4
      end else if ((s.fill == interp_shaping_pkg::FILL_FULL &&
                    !s.mode[interp_shaping_pkg::MODE_HALF_IRQ]) ||
                   (s.fill == interp_shaping_pkg::FILL_HALF &&
                    s.mode[interp_shaping_pkg::MODE_HALF_IRQ])) begin
        next_s.irqN = 1'b0; // see RQ1 see RQ18
      end
    end
    next_s.nwp = next_s.started && next_s.fill != 4'h0 &&
                 next_s.fill != interp_shaping_pkg::FILL_FULL; // see RQ19
    // Equalization mode latched from the mode word
    next_s.even = next_s.mode[interp_shaping_pkg::MODE_EVEN]; // see RQ12
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.mode <= interp_shaping_pkg::MODE_RESET;
      s.period <= interp_shaping_pkg::PERIOD_RESET;
      s.irqN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign axisPulse = s.pulse;
  assign evenActive = s.even;
  assign link.prebufferFillCount = s.fill;
  assign link.nextWritePermitted = s.nwp;
  assign link.bufferSpaceIrqN = s.irqN;
  assign link.driveBusy = s.started;
endmodule : interp_shaping_device

// File: logic/interp_shaping_host.sv
/*
  Host end: turns register writes from software into link writes and
  reports device status and refused commands.
  Assumes the device end on the link and one clock mclk.
*/
`timescale 1ns/1ps
module interp_shaping_host (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  interp_shaping_if.host    link,
  input  wire logic [2:0]   usrAddr,
  input  wire logic [15:0]  usrWdata,
  input  wire logic         usrWr,
  input  wire logic         usrRd,
  output logic [15:0]       usrRdata
);
  // ==========================================================
  // State
  typedef struct packed {
    logic        wrStrobe;
    logic [2:0]  wrSel;
    logic [15:0] wrData;
    logic [15:0] rdata;
    logic [15:0] mode;
    logic [1:0]  err;
  } state_s;

  state_s s;
  state_s next_s;

  always_comb begin
    next_s = s;
    next_s.wrStrobe = 1'b0;
    next_s.rdata = 16'h0000;
    if (usrWr) begin
      if (usrAddr == interp_shaping_pkg::REG_ERROR) begin
        next_s.err = s.err & ~usrWdata[1:0];
      end else if (usrAddr == interp_shaping_pkg::SEL_CMD &&
                   s.mode[interp_shaping_pkg::MODE_EVEN]) begin
        next_s.err[0] = 1'b1; // see RQ16
      end else if (usrAddr == interp_shaping_pkg::SEL_CMD &&
                   !link.nextWritePermitted && link.driveBusy) begin
        next_s.err[1] = 1'b1; // see RQ2
      end else if (usrAddr != interp_shaping_pkg::REG_STATUS) begin
        next_s.wrStrobe = 1'b1;
        next_s.wrSel = usrAddr;
        next_s.wrData = usrWdata;
        if (usrAddr == interp_shaping_pkg::SEL_MODE) begin
          next_s.mode = usrWdata;
        end
      end
    end
    if (usrRd) begin
      case (usrAddr)
        interp_shaping_pkg::REG_STATUS:
          next_s.rdata = {9'h000, link.driveBusy, link.bufferSpaceIrqN,
                          link.nextWritePermitted, link.prebufferFillCount};
        interp_shaping_pkg::REG_ERROR: next_s.rdata = {14'h0000, s.err};
        interp_shaping_pkg::SEL_MODE:  next_s.rdata = s.mode;
        default: next_s.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.wrStrobe = s.wrStrobe;
  assign link.wrSel = s.wrSel;
  assign link.wrData = s.wrData;
  assign usrRdata = s.rdata;
endmodule : interp_shaping_host

// File: logic/interp_shaping_if.sv
/*
  Link between the host end and the interpolation device end.
  Assumes both ends share mclk; all signals are driven from flip-flops.
*/
`timescale 1ns/1ps
interface interp_shaping_if;
  logic        wrStrobe;
  logic [2:0]  wrSel;
  logic [15:0] wrData;
  logic [3:0]  prebufferFillCount;
  logic        nextWritePermitted;
  logic        bufferSpaceIrqN;
  logic        driveBusy;

  modport device (input wrStrobe, wrSel, wrData,
                  output prebufferFillCount, nextWritePermitted, bufferSpaceIrqN, driveBusy);
  modport host   (output wrStrobe, wrSel, wrData,
                  input prebufferFillCount, nextWritePermitted, bufferSpaceIrqN, driveBusy);
endinterface : interp_shaping_if

// File: logic/interp_shaping_pkg.sv
/*
  Shared constants for the bit-pattern interpolation shaping block:
  link select codes, command codes, mode word fields, buffer geometry,
  speed scaling factors and the host register map.
  Assumes both ends are compiled against this package.
*/
package interp_shaping_pkg;
  // ==========================================================
  // Link write selects
  localparam logic [2:0] SEL_MODE   = 3'h0;
  localparam logic [2:0] SEL_AXIS0  = 3'h1;
  localparam logic [2:0] SEL_CMD    = 3'h4;
  localparam logic [2:0] SEL_PERIOD = 3'h5;
  // ==========================================================
  // Interpolation commands
  localparam logic [7:0] CMD_BP2 = 8'h66;
  localparam logic [7:0] CMD_BP3 = 8'h67;
  localparam logic [7:0] CMD_BP4 = 8'h68;
  localparam logic [7:0] CMD_MODE = 8'h2A;
  // ==========================================================
  // Mode word fields
  localparam int MODE_SPD_LO   = 6;
  localparam int MODE_SPD_HI   = 7;
  localparam int MODE_EVEN     = 8;
  localparam int MODE_HALF_IRQ = 14;
  localparam logic [1:0] SPD_OFF    = 2'h0;
  localparam logic [1:0] SPD_2SIMPLE = 2'h1;
  localparam logic [1:0] SPD_3SIMPLE = 2'h2;
  localparam logic [1:0] SPD_2ACCUR  = 2'h3;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'h0040;
  // ==========================================================
  // Buffer geometry
  localparam int STAGES     = 8;
  localparam int STAGE_BITS = 16;
  localparam int SUBSTEPS   = 8;
  localparam logic [3:0] FILL_FULL  = 4'h8;
  localparam logic [3:0] FILL_HALF  = 4'h4;
  // ==========================================================
  // Period scaling, fixed point with 7 fraction bits
  localparam int SCALE_SHIFT = 7;
  localparam logic [7:0] SCALE_ONE  = 8'h80;
  localparam logic [7:0] SCALE_SQ2  = 8'hB5;
  localparam logic [7:0] SCALE_SQ3  = 8'hDE;
  localparam logic [7:0] EVEN_WRAP  = 8'h80;
  // ==========================================================
  // Host register map
  localparam logic [2:0] REG_STATUS = 3'h6;
  localparam logic [2:0] REG_ERROR  = 3'h7;
endpackage : interp_shaping_pkg

// File: verification/interp_shaping_monitor.sv
/* Assertion checker on the link between host end and device end.
   Assumes the testbench wires the link signals to its inputs. */
`timescale 1ns/1ps
module interp_shaping_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        wrStrobe,
  input wire logic [2:0]  wrSel,
  input wire logic [15:0] wrData,
  input wire logic [3:0]  prebufferFillCount,
  input wire logic        nextWritePermitted,
  input wire logic        bufferSpaceIrqN,
  input wire logic        driveBusy
);
  logic [3:0] fill;
  logic       halfSel;
  logic       cmdOk;
  assign fill = prebufferFillCount;
  assign cmdOk = wrStrobe && wrSel == interp_shaping_pkg::SEL_CMD && fill != 4'h8
    && wrData[7:0] inside {8'h66, 8'h67, 8'h68};
  // Mirror of the interrupt timing select from mode writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) halfSel <= 1'b0;
    else if (wrStrobe && wrSel == interp_shaping_pkg::SEL_MODE) halfSel <= wrData[14];
  end
  // ====
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence fellTo(logic [3:0] n);
    $past(fill) == (n + 4'h1) && fill == n;
  endsequence
  a_irq_full: assert property (!halfSel ##0 fellTo(4'h7) |-> !bufferSpaceIrqN)
    else $error("no irq on 8 to 7");
  a_irq_half: assert property (halfSel ##0 fellTo(4'h3) |-> !bufferSpaceIrqN)
    else $error("no irq on 4 to 3");
  a_irq_cause: assert property ($fell(bufferSpaceIrqN) |-> fellTo(halfSel ? 4'h3 : 4'h7))
    else $error("irq without fill fall");
  a_irq_hold: assert property (!bufferSpaceIrqN && !cmdOk |=> !bufferSpaceIrqN || !driveBusy)
    else $error("irq left early");
  a_cmd_release: assert property (cmdOk |=> bufferSpaceIrqN && driveBusy)
    else $error("command kept irq");
  a_idle_release: assert property (!driveBusy |-> bufferSpaceIrqN)
    else $error("irq while idle");
  a_flag_level: assert property (nextWritePermitted == (driveBusy && fill != 4'h0 && fill != 4'h8))
    else $error("next write flag wrong");
  a_busy_fill: assert property (driveBusy == (fill != 4'h0))
    else $error("busy and fill disagree");
  a_fill_step: assert property ($changed(fill) |-> fill == $past(fill) + 4'h1 || fill + 4'h1 == $past(fill))
    else $error("fill jumped");
  a_fill_rise: assert property (cmdOk |=> fill >= $past(fill) && fill != 4'h0)
    else $error("command not counted");
  a_no_rise: assert property (!cmdOk |=> fill <= $past(fill))
    else $error("fill rose alone");
endmodule : interp_shaping_monitor

// File: verification/testbench.sv
/* Testbench for the host end and device end joined by one link.
   Assumes the design package, the link interface and both ends. */
`timescale 1ns/1ps
module testbench;
  logic mclk, rst_n, usrWr, usrRd, evenActive;
  logic [2:0] usrAddr, axisPulse;
  logic [15:0] usrWdata, usrRdata, st;
  logic [15:0] pat [3];
  int num_errors, n_compared, cycles, cnt0, cnt1;
  interp_shaping_if linkBus ();
  interp_shaping_device interp_shaping_device_i (.mclk(mclk), .rst_n(rst_n),
    .link(linkBus.device), .axisPulse(axisPulse), .evenActive(evenActive));
  interp_shaping_host interp_shaping_host_i (.mclk(mclk), .rst_n(rst_n), .link(linkBus.host),
    .usrAddr(usrAddr), .usrWdata(usrWdata), .usrWr(usrWr), .usrRd(usrRd), .usrRdata(usrRdata));
  interp_shaping_monitor interp_shaping_monitor_i (.mclk(mclk), .rst_n(rst_n),
    .wrStrobe(linkBus.wrStrobe), .wrSel(linkBus.wrSel), .wrData(linkBus.wrData),
    .prebufferFillCount(linkBus.prebufferFillCount),
    .nextWritePermitted(linkBus.nextWritePermitted),
    .bufferSpaceIrqN(linkBus.bufferSpaceIrqN), .driveBusy(linkBus.driveBusy));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Pulse tally and hang limit
  always @(posedge mclk) begin
    cycles++;
    cnt0 += axisPulse[0];
    cnt1 += axisPulse[1];
    if (cycles == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ====
  // Report, check and bus tasks
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    usrWr <= 1'b1;
    usrAddr <= a;
    usrWdata <= d;
    @(posedge mclk);
    usrWr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] q);
    usrRd <= 1'b1;
    usrAddr <= a;
    @(posedge mclk);
    usrRd <= 1'b0;
    #1 q = usrRdata;
    @(posedge mclk);
  endtask : rd
  task automatic stage(input logic [7:0] code);
    for (int a = 0; a < 3; a++) wr(3'(a + 1), pat[a]);
    wr(3'h4, {8'h00, code});
  endtask : stage
  task automatic poll(input logic [15:0] mask, input logic [15:0] want);
    rd(3'h6, st);
    for (int i = 0; i < 6000 && (st & mask) !== 16'h0000; i++) rd(3'h6, st);
    check(st, want, "status after wait");
  endtask : poll
  // ====
  // Scenarios
  task automatic t_idle();
    wr(3'h6, 16'hFFFF);
    rd(3'h6, st);
    check(st, 16'h0020, "idle status");
  endtask : t_idle
  task automatic t_full();
    pat = '{16'hFFFF, 16'h5555, 16'h0000};
    wr(3'h0, 16'h0003);
    cnt0 = 0;
    cnt1 = 0;
    repeat (8) stage(8'h66);
    rd(3'h6, st);
    check(st, 16'h0068, "full");
    stage(8'h66);
    rd(3'h7, st);
    check(st, 16'h0002, "stage past full");
    wr(3'h7, 16'h0002);
    poll(16'h0020, 16'h0057);
    stage(8'h67);
    rd(3'h6, st);
    check(st, 16'h0068, "irq after command");
    poll(16'h0040, 16'h0020);
    check(16'(cnt0), 16'h0090, "long axis pulses");
    check(16'(cnt1), 16'h0048, "short axis pulses");
  endtask : t_full
  task automatic t_half();
    wr(3'h0, 16'h4003);
    repeat (5) stage(8'h68);
    poll(16'h0020, 16'h0053);
    poll(16'h0040, 16'h0020);
  endtask : t_half
  task automatic t_even();
    int n;
    pat = '{16'hFFFF, 16'h000F, 16'h0000};
    wr(3'h0, 16'h0003);
    cnt0 = 0;
    cnt1 = 0;
    stage(8'h66);
    // Equalization switched on mid-stage is the only way it meets a loaded stage
    wr(3'h0, 16'h0103);
    rd(3'h7, st);
    check({15'h0000, evenActive}, 16'h0001, "equalize flag");
    stage(8'h66);
    rd(3'h7, st);
    check(st, 16'h0001, "equalized command");
    rd(3'h6, st);
    check(st, 16'h0071, "no stage loaded");
    wr(3'h7, 16'hFFFF);
    for (n = 0; n < 600 && axisPulse[1] !== 1'b1; n++) @(posedge mclk);
    @(posedge mclk);
    for (n = 1; n < 600 && axisPulse[1] !== 1'b1; n++) @(posedge mclk);
    // Four short-axis pulses spread over sixteen 64-cycle steps
    check(16'(n), 16'(16 * 64 / 4), "short axis spacing");
    poll(16'h0040, 16'h0020);
    check(16'(cnt0), 16'h0010, "equalized long axis");
    check(16'(cnt1), 16'h0004, "equalized short axis");
  endtask : t_even
  task automatic t_speed();
    logic [15:0] mode [5] = '{16'h0003, 16'h0043, 16'h0083, 16'h0087, 16'h00C3};
    logic [7:0] f [5] = '{8'h80, 8'hB5, 8'hB5, 8'hDE, 8'hB5};
    int n;
    pat = '{16'hFFFF, 16'hFFFF, 16'hFFFF};
    wr(3'h5, 16'h0040);
    for (int m = 0; m < 5; m++) begin
      wr(3'h0, mode[m]);
      stage(8'h66);
      for (n = 0; n < 300 && axisPulse[0] !== 1'b1; n++) @(posedge mclk);
      @(posedge mclk);
      for (n = 1; n < 300 && axisPulse[0] !== 1'b1; n++) @(posedge mclk);
      check(16'(n), 16'(8 * ((64 * f[m]) >> 10)), "step period");
      poll(16'h0040, 16'h0020);
    end
  endtask : t_speed
  initial begin
    rst_n = 1'b0;
    usrWr = 1'b0;
    usrRd = 1'b0;
    usrAddr = 3'h0;
    usrWdata = 16'h0000;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_idle();
    t_full();
    t_half();
    t_even();
    t_speed();
    report_and_stop();
  end
endmodule : testbench
